// ===== include/dbrb_regs.vh
// register map, field positions and reset values of the daq register bank
`ifndef DBRB_REGS_VH
`define DBRB_REGS_VH

// register indices; byte address is four times the index
`define DBRB_IDX_STATUS 5'h07
`define DBRB_IDX_IRQ_CLR 5'h08
`define DBRB_IDX_FIFO_CLR 5'h09
`define DBRB_IDX_DAC0_LO 5'h0A
`define DBRB_IDX_DAC0_HI 5'h0B
`define DBRB_IDX_DAC1_LO 5'h0C
`define DBRB_IDX_DAC1_HI 5'h0D
`define DBRB_IDX_REF0 5'h0E
`define DBRB_IDX_REF1 5'h0F
`define DBRB_IDX_DIO_LO 5'h10
`define DBRB_IDX_DIO_HI 5'h11
`define DBRB_IDX_CAL_VAL 5'h12
`define DBRB_IDX_CAL_CMD 5'h13
`define DBRB_IDX_BOARD_IDENTIFIER 5'h14
`define DBRB_IDX_TMR_CNT0 5'h18
`define DBRB_IDX_TMR_CNT1 5'h1A
`define DBRB_IDX_TMR_CNT2 5'h1C
`define DBRB_IDX_TMR_CTRL 5'h1E

// reference byte fields
`define DBRB_REF_LEVEL_BIT 0
`define DBRB_REF_POLARITY_BIT 1
`define DBRB_REF_SOURCE_BIT 2
`define DBRB_REF_GATE_BIT 3

// status byte fields
`define DBRB_STAT_FIFO_EMPTY_BIT 0
`define DBRB_STAT_IRQ_BIT 3

// reset values
`define DBRB_RST_DIGOUT 16'h0000
`define DBRB_RST_DAC_CODE 16'h0000
`define DBRB_RST_REF 4'h0
`define DBRB_RST_CAL_VAL 8'h00
`define DBRB_RST_CAL_CMD 4'h0

// number of defined calibration commands
`define DBRB_CAL_POINTS 12

// htrans encoding
`define DBRB_HTRANS_NONSEQ 2'h2

`endif

// ===== design/dbrb_register_bank.v
// ahb-lite register bank of the daq card: dac, reference, digital io, calibration, timer window
`timescale 1ns/1ps
`include "dbrb_regs.vh"

module dbrb_register_bank #(
  parameter ADDR_W = 32,
  parameter DAC_W = 16,
  parameter DIO_W = 16
) (
  input wire core_clk_in,                     // 50 MHz bus clock
  input wire nrst_in,                         // synchronous reset, active low
  input wire hsel_in,                         // slave select
  input wire [ADDR_W-1:0] haddr_in,           // byte address
  input wire [1:0] htrans_in,                 // transfer type
  input wire hwrite_in,                       // 1 = write
  input wire [2:0] hsize_in,                  // transfer size
  input wire [31:0] hwdata_in,                // write data
  input wire hready_in,                       // bus ready
  output reg hreadyout_out,                   // slave ready
  output reg hresp_out,                       // always okay
  output reg [31:0] hrdata_out,               // read data
  input wire irq_event_in,                    // acquisition interrupt event pulse
  input wire fifo_empty_in,                   // sample fifo empty level
  output reg irq_pending_out,                 // sticky interrupt flag
  output reg fifo_clear_out,                  // one-cycle fifo clear pulse
  output reg [DAC_W-1:0] dac0_code_out,       // code at converter 0
  output reg [DAC_W-1:0] dac1_code_out,       // code at converter 1
  output reg [1:0] dac_ref_level_sel_out,     // per channel: 0 = 5 V, 1 = 10 V
  output reg [1:0] dac_polarity_sel_out,      // per channel: 0 bipolar, 1 unipolar
  output reg [1:0] dac_ref_source_sel_out,    // per channel: 0 internal, 1 external
  output reg dac0_load_gate_en_out,           // channel 0 gated loading
  output reg dac1_load_gate_en_out,           // channel 1 gated loading
  input wire [DIO_W-1:0] digin_bits_in,       // digital input levels
  output reg [DIO_W-1:0] digout_bits_out,     // digital output latches
  output reg [7:0] cal_value_out,             // calibration value
  output reg [3:0] cal_command_out,           // calibration command
  output reg [`DBRB_CAL_POINTS-1:0] cal_trim_sel_out, // one-hot trim point
  output reg cal_strobe_out,                  // pulse after command write
  input wire [3:0] board_ident_bits_in,       // board identifier switches
  output reg [1:0] tmr_sel_out,               // 0..2 counters, 3 control word
  output reg tmr_wr_out,                      // timer write strobe
  output reg tmr_rd_out,                      // timer read strobe
  output reg [15:0] tmr_wdata_out,            // timer write word
  input wire [15:0] tmr_rdata_in              // timer read word, valid with tmr_rd_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function is_tmr;
    input [4:0] idx;
    begin
      is_tmr = (idx == `DBRB_IDX_TMR_CNT0) || (idx == `DBRB_IDX_TMR_CNT1) ||
               (idx == `DBRB_IDX_TMR_CNT2) || (idx == `DBRB_IDX_TMR_CTRL);
    end
  endfunction

  function [`DBRB_CAL_POINTS-1:0] cal_decode;
    input [3:0] cmd;
    begin
      cal_decode = {`DBRB_CAL_POINTS{1'b0}};
      // codes above eleven select no trim point
      if (cmd < 4'hC) begin
        cal_decode[cmd] = 1'b1;
      end
    end
  endfunction

  // low or high byte of a 16-bit code, picked by the index parity
  function [15:0] put_byte;
    input [15:0] word;
    input hi;
    input [7:0] b;
    begin
      put_byte = word;
      if (hi) begin
        put_byte[15:8] = b;
      end else begin
        put_byte[7:0] = b;
      end
    end
  endfunction

  // true for either byte index of the code pair starting at lo
  function hits_pair;
    input [4:0] idx;
    input [4:0] lo;
    begin
      hits_pair = (idx[4:1] == lo[4:1]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address phase capture

  reg d_wr;
  reg d_rd;
  reg [4:0] d_idx;
  reg [DAC_W-1:0] dac0_hold;
  reg [DAC_W-1:0] dac1_hold;
  reg [31:0] next_rdata;

  wire take = hsel_in && hready_in && (htrans_in == `DBRB_HTRANS_NONSEQ);
  // upper address bits beyond the window must be zero or the access is dropped; low two bits ignored
  wire [4:0] a_idx = haddr_in[6:2];
  wire in_map = (haddr_in[ADDR_W-1:7] == {(ADDR_W-7){1'b0}});
  wire [7:0] wbyte = hwdata_in[7:0];
  wire wr_en = d_wr;
  wire ld0 = d_rd && dac0_load_gate_en_out && hits_pair(d_idx, `DBRB_IDX_DAC0_LO);
  wire ld1 = d_rd && dac1_load_gate_en_out && hits_pair(d_idx, `DBRB_IDX_DAC1_LO);

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      d_wr <= 1'b0;
      d_rd <= 1'b0;
      d_idx <= 5'h00;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      tmr_rd_out <= 1'b0;
      tmr_sel_out <= 2'h0;
    end else begin
      hresp_out <= 1'b0;
      if (take) begin
        d_wr <= hwrite_in && in_map;
        d_rd <= !hwrite_in && in_map;
        d_idx <= a_idx;
        // reads take one wait state so the timer and inputs are sampled cleanly
        hreadyout_out <= hwrite_in;
        tmr_rd_out <= !hwrite_in && in_map && is_tmr(a_idx);
        tmr_sel_out <= a_idx[2:1];
      end else begin
        d_wr <= 1'b0;
        d_rd <= 1'b0;
        hreadyout_out <= 1'b1;
        tmr_rd_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered at the end of the wait state

  always @* begin
    next_rdata = 32'h00000000;
    case (d_idx)
      `DBRB_IDX_STATUS: begin
        next_rdata[`DBRB_STAT_IRQ_BIT] = irq_pending_out;
        next_rdata[`DBRB_STAT_FIFO_EMPTY_BIT] = fifo_empty_in || fifo_clear_out;
      end
      `DBRB_IDX_DIO_LO: begin
        next_rdata[7:0] = digin_bits_in[7:0];
      end
      `DBRB_IDX_DIO_HI: begin
        next_rdata[7:0] = digin_bits_in[15:8];
      end
      `DBRB_IDX_BOARD_IDENTIFIER: begin
        next_rdata[3:0] = board_ident_bits_in;
      end
      `DBRB_IDX_TMR_CNT0, `DBRB_IDX_TMR_CNT1,
      `DBRB_IDX_TMR_CNT2, `DBRB_IDX_TMR_CTRL: begin
        next_rdata[15:0] = tmr_rdata_in;
      end
      // load strobes and write-only registers read as zero
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (!hreadyout_out) begin
      // an unmapped read still answers, with zero rather than stale data
      if (d_rd) begin
        hrdata_out <= next_rdata;
      end else begin
        hrdata_out <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and strobes

  // data phase write decode shared by the flag processes
  wire wr_irq_clr = wr_en && (d_idx == `DBRB_IDX_IRQ_CLR);
  wire wr_fifo_clr = wr_en && (d_idx == `DBRB_IDX_FIFO_CLR);
  wire wr_tmr = wr_en && is_tmr(d_idx);
  wire wr_cal_cmd = wr_en && (d_idx == `DBRB_IDX_CAL_CMD);

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      irq_pending_out <= 1'b0;
    end else begin
      // a new event in the clearing cycle keeps the flag set
      if (irq_event_in) begin
        irq_pending_out <= 1'b1;
      end else if (wr_irq_clr) begin
        irq_pending_out <= 1'b0;
      end
    end
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      fifo_clear_out <= 1'b0;
    end else begin
      // data written is ignored; the write itself is the command
      fifo_clear_out <= wr_fifo_clr;
    end
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      tmr_wr_out <= 1'b0;
      tmr_wdata_out <= 16'h0000;
    end else begin
      tmr_wr_out <= wr_tmr;
      if (wr_tmr) begin
        // whole word handed over at once, the timer never sees byte halves
        tmr_wdata_out <= hwdata_in[15:0];
      end
    end
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cal_strobe_out <= 1'b0;
    end else begin
      cal_strobe_out <= wr_cal_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // d/a codes

  reg [DAC_W-1:0] next_dac0_hold;
  reg [DAC_W-1:0] next_dac0_code;
  reg [DAC_W-1:0] next_dac1_hold;
  reg [DAC_W-1:0] next_dac1_code;

  always @* begin
    next_dac0_hold = dac0_hold;
    next_dac0_code = dac0_code_out;
    if (wr_en && hits_pair(d_idx, `DBRB_IDX_DAC0_LO)) begin
      next_dac0_hold = put_byte(dac0_hold, d_idx[0], wbyte);
      if (!dac0_load_gate_en_out) begin
        next_dac0_code = put_byte(dac0_code_out, d_idx[0], wbyte);
      end
    end
    // with the load gate on, held code reaches the converter only on a load read; writes alone never move it
    if (ld0) begin
      next_dac0_code = dac0_hold;
    end
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      dac0_hold <= `DBRB_RST_DAC_CODE;
      dac0_code_out <= `DBRB_RST_DAC_CODE;
    end else begin
      dac0_hold <= next_dac0_hold;
      dac0_code_out <= next_dac0_code;
    end
  end

  always @* begin
    next_dac1_hold = dac1_hold;
    next_dac1_code = dac1_code_out;
    if (wr_en && hits_pair(d_idx, `DBRB_IDX_DAC1_LO)) begin
      next_dac1_hold = put_byte(dac1_hold, d_idx[0], wbyte);
      if (!dac1_load_gate_en_out) begin
        next_dac1_code = put_byte(dac1_code_out, d_idx[0], wbyte);
      end
    end
    if (ld1) begin
      next_dac1_code = dac1_hold;
    end
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      dac1_hold <= `DBRB_RST_DAC_CODE;
      dac1_code_out <= `DBRB_RST_DAC_CODE;
    end else begin
      dac1_hold <= next_dac1_hold;
      dac1_code_out <= next_dac1_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference control, one write-only byte per channel

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      dac_ref_level_sel_out <= 2'h0;
      dac_polarity_sel_out <= 2'h0;
      dac_ref_source_sel_out <= 2'h0;
      dac0_load_gate_en_out <= 1'b0;
      dac1_load_gate_en_out <= 1'b0;
    end else if (wr_en) begin
      case (d_idx)
        `DBRB_IDX_REF0: begin
          dac_ref_level_sel_out[0] <= wbyte[`DBRB_REF_LEVEL_BIT];
          dac_polarity_sel_out[0] <= wbyte[`DBRB_REF_POLARITY_BIT];
          dac_ref_source_sel_out[0] <= wbyte[`DBRB_REF_SOURCE_BIT];
          dac0_load_gate_en_out <= wbyte[`DBRB_REF_GATE_BIT];
        end
        `DBRB_IDX_REF1: begin
          dac_ref_level_sel_out[1] <= wbyte[`DBRB_REF_LEVEL_BIT];
          dac_polarity_sel_out[1] <= wbyte[`DBRB_REF_POLARITY_BIT];
          dac_ref_source_sel_out[1] <= wbyte[`DBRB_REF_SOURCE_BIT];
          dac1_load_gate_en_out <= wbyte[`DBRB_REF_GATE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital outputs

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      digout_bits_out <= `DBRB_RST_DIGOUT;
    end else if (wr_en) begin
      case (d_idx)
        `DBRB_IDX_DIO_LO: begin
          digout_bits_out[7:0] <= wbyte;
        end
        `DBRB_IDX_DIO_HI: begin
          digout_bits_out[15:8] <= wbyte;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration port

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cal_value_out <= `DBRB_RST_CAL_VAL;
      cal_command_out <= `DBRB_RST_CAL_CMD;
      cal_trim_sel_out <= {`DBRB_CAL_POINTS{1'b0}};
    end else if (wr_en) begin
      case (d_idx)
        `DBRB_IDX_CAL_VAL: begin
          cal_value_out <= wbyte;
        end
        `DBRB_IDX_CAL_CMD: begin
          cal_command_out <= wbyte[3:0];
          cal_trim_sel_out <= cal_decode(wbyte[3:0]);
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// ===== bench/dbrb_register_bank_props.sv
// checker for the daq register bank: clears, dac gating, digital io, timer decode
`timescale 1ns/1ps
module dbrb_register_bank_props #(
  parameter ADDR_W = 32,
  parameter DAC_W = 16,
  parameter DIO_W = 16
) (
  input wire core_clk_in, // clock
  input wire nrst_in, // reset
  input wire hsel_in, // select
  input wire [ADDR_W-1:0] haddr_in, // address
  input wire [1:0] htrans_in, // type
  input wire hwrite_in, // write
  input wire [31:0] hwdata_in, // wdata
  input wire hready_in, // ready
  input wire hreadyout_out, // ready out
  input wire [31:0] hrdata_out, // rdata
  input wire irq_event_in, // event
  input wire irq_pending_out, // irq
  input wire fifo_clear_out, // clear
  input wire [DAC_W-1:0] dac0_code_out, // code
  input wire dac0_load_gate_en_out, // gate
  input wire [DIO_W-1:0] digin_bits_in, // inputs
  input wire [DIO_W-1:0] digout_bits_out, // outputs
  input wire tmr_wr_out, // timer write
  input wire [1:0] tmr_sel_out // timer select
);
  logic wr_q;
  logic rd_q;
  logic [4:0] idx_q;
  // hreadyout in the take so a held address phase counts once
  wire take = hsel_in && hready_in && hreadyout_out && htrans_in == 2'h2
    && haddr_in[ADDR_W-1:7] == 0;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  always @(posedge core_clk_in) begin
    wr_q <= nrst_in && take && hwrite_in;
    rd_q <= nrst_in && take && !hwrite_in;
    if (take) begin
      idx_q <= haddr_in[6:2];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_irq_clr; wr_q && idx_q == 5'h08 && !irq_event_in |=> !irq_pending_out; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq flag kept");
  property p_fifo_clr; wr_q && idx_q == 5'h09 |=> fifo_clear_out; endproperty
  a_fifo_clr: assert property (p_fifo_clr) else $error("no fifo clear");
  property p_irq_set; $rose(irq_pending_out) |-> $past(irq_event_in); endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq without event");
  property p_dout; wr_q && idx_q == 5'h10 |=> digout_bits_out[7:0] == $past(hwdata_in[7:0]);
  endproperty
  a_dout: assert property (p_dout) else $error("output latch wrong");
  property p_dac_now; wr_q && idx_q == 5'h0B && !dac0_load_gate_en_out
    |=> dac0_code_out[15:8] == $past(hwdata_in[7:0]); endproperty
  a_dac_now: assert property (p_dac_now) else $error("code not passed");
  property p_dac_hold; dac0_load_gate_en_out && !(rd_q && idx_q[4:1] == 4'h5)
    |=> $stable(dac0_code_out); endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("gated code moved");
  property p_din; rd_q && idx_q == 5'h10 |=> hrdata_out[7:0] == digin_bits_in[7:0]; endproperty
  a_din: assert property (p_din) else $error("input read wrong");
  property p_tmr; wr_q && idx_q == 5'h18 |=> tmr_wr_out && tmr_sel_out == 2'h0; endproperty
  a_tmr: assert property (p_tmr) else $error("timer route wrong");
  property p_rst; $rose(nrst_in) |-> digout_bits_out == 0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not zero");
endmodule
bind dbrb_register_bank dbrb_register_bank_props #(.ADDR_W(ADDR_W), .DAC_W(DAC_W),
  .DIO_W(DIO_W)) dbrb_register_bank_props_i (.core_clk_in, .nrst_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out, .hrdata_out,
  .irq_event_in, .irq_pending_out, .fifo_clear_out, .dac0_code_out, .dac0_load_gate_en_out,
  .digin_bits_in, .digout_bits_out, .tmr_wr_out, .tmr_sel_out);

// ===== bench/dbrb_tmr_model.sv
// behavioural interval timer register file standing behind the timer window
`timescale 1ns/1ps
module dbrb_tmr_model (
  input wire core_clk_in, // clock
  input wire [1:0] tmr_sel_in, // register select
  input wire tmr_wr_in, // write strobe
  input wire tmr_rd_in, // read strobe
  input wire [15:0] tmr_wdata_in, // write word
  output wire [15:0] tmr_rdata_out // read word
);
  logic [15:0] regs [4];
  logic [15:0] junk = 16'hA5A5;
  always @(posedge core_clk_in) begin
    junk <= ~junk;
    if (tmr_wr_in) begin
      regs[tmr_sel_in] <= tmr_wdata_in;
    end
  end
  // outside a read strobe the word toggles, so a late sample shows
  assign tmr_rdata_out = tmr_rd_in ? regs[tmr_sel_in] : junk;
endmodule

// ===== bench/dbrb_register_bank_tb_top.sv
// testbench of the daq register bank driven as an ahb-lite master
`timescale 1ns/1ps
module dbrb_register_bank_tb_top;
  logic core_clk_in, nrst_in, hsel_in, hwrite_in, irq_event_in, fifo_empty_in;
  logic [31:0] haddr_in, hwdata_in;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic [15:0] digin_bits_in;
  logic [3:0] board_ident_bits_in;
  wire hready_in, hreadyout_out, hresp_out, irq_pending_out, fifo_clear_out, cal_strobe_out;
  wire dac0_load_gate_en_out, dac1_load_gate_en_out, tmr_wr_out, tmr_rd_out;
  wire [31:0] hrdata_out;
  wire [15:0] dac0_code_out, dac1_code_out, digout_bits_out, tmr_wdata_out, tmr_rdata_in;
  wire [1:0] dac_ref_level_sel_out, dac_polarity_sel_out, dac_ref_source_sel_out, tmr_sel_out;
  wire [7:0] cal_value_out;
  wire [3:0] cal_command_out;
  wire [11:0] cal_trim_sel_out;
  wire [7:0] ref_bits = {dac1_load_gate_en_out, dac0_load_gate_en_out, dac_ref_source_sel_out,
    dac_polarity_sel_out, dac_ref_level_sel_out};
  int errors, tests_run, k;
  assign hready_in = hreadyout_out;
  dbrb_register_bank dbrb_register_bank_i (.core_clk_in, .nrst_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hreadyout_out, .hresp_out,
    .hrdata_out, .irq_event_in, .fifo_empty_in, .irq_pending_out, .fifo_clear_out,
    .dac0_code_out, .dac1_code_out, .dac_ref_level_sel_out, .dac_polarity_sel_out,
    .dac_ref_source_sel_out, .dac0_load_gate_en_out, .dac1_load_gate_en_out, .digin_bits_in,
    .digout_bits_out, .cal_value_out, .cal_command_out, .cal_trim_sel_out, .cal_strobe_out,
    .board_ident_bits_in, .tmr_sel_out, .tmr_wr_out, .tmr_rd_out, .tmr_wdata_out,
    .tmr_rdata_in);
  dbrb_tmr_model dbrb_tmr_model_i (.core_clk_in, .tmr_sel_in(tmr_sel_out),
    .tmr_wr_in(tmr_wr_out), .tmr_rd_in(tmr_rd_out), .tmr_wdata_in(tmr_wdata_out),
    .tmr_rdata_out(tmr_rdata_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single word transfer; only the watchdog ends a wait
  task automatic xf(input [5:0] idx, input w, input [31:0] d, output [31:0] q);
    haddr_in <= {24'h0, idx, 2'b00};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    @(posedge core_clk_in);
    while (!hreadyout_out) @(posedge core_clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    @(posedge core_clk_in);
    while (!hreadyout_out) @(posedge core_clk_in);
    q = hrdata_out;
    #1;
  endtask
  task automatic wr(input [5:0] idx, input [31:0] d);
    logic [31:0] q;
    xf(idx, 1'b1, d, q);
  endtask
  task automatic rd(input [5:0] idx, input [31:0] exp);
    logic [31:0] q;
    xf(idx, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wrap_up;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  initial begin
    #50000;
    errors++;
    wrap_up;
  end
  initial begin
    errors = 0;
    tests_run = 0;
    {nrst_in, hwrite_in, irq_event_in, haddr_in, hwdata_in, htrans_in} = '0;
    hsel_in = 1'b1;
    hsize_in = 3'h2;
    fifo_empty_in = 1'b1;
    digin_bits_in = 16'h9A3C;
    board_ident_bits_in = 4'hB;
    repeat (3) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    #1;
    chk(digout_bits_out, 32'h0);
    wr(6'h10, 32'h5A);
    wr(6'h11, 32'hC3);
    chk(digout_bits_out, 32'hC35A);
    rd(6'h10, 32'h3C);
    rd(6'h11, 32'h9A);
    rd(6'h14, 32'hB);
    rd(6'h20, 32'h0);
    rd(6'h0E, 32'h0);
    chk(hresp_out, 32'h0);
    irq_event_in <= 1'b1;
    @(posedge core_clk_in);
    irq_event_in <= 1'b0;
    #1;
    chk(irq_pending_out, 32'h1);
    rd(6'h07, 32'h9);
    wr(6'h08, 32'hFF);
    chk(irq_pending_out, 32'h0);
    wr(6'h09, 32'h0);
    chk(fifo_clear_out, 32'h1);
    fifo_empty_in <= 1'b0;
    rd(6'h07, 32'h0);
    wr(6'h0A, 32'h34);
    chk(dac0_code_out, 32'h34);
    wr(6'h0B, 32'h12);
    chk(dac0_code_out, 32'h1234);
    wr(6'h0E, 32'hF);
    wr(6'h0F, 32'hA);
    chk(ref_bits, 32'hDD);
    wr(6'h0A, 32'h78);
    wr(6'h0B, 32'h56);
    chk(dac0_code_out, 32'h1234);
    rd(6'h0B, 32'h0);
    chk(dac0_code_out, 32'h5678);
    wr(6'h0C, 32'hCD);
    wr(6'h0D, 32'hAB);
    chk(dac1_code_out, 32'h0);
    rd(6'h0C, 32'h0);
    chk(dac1_code_out, 32'hABCD);
    for (k = 0; k < 16; k++) begin
      wr(6'h12, 32'hC0 + k);
      wr(6'h13, 32'hF0 | k);
      chk(cal_strobe_out, 32'h1);
      chk({cal_value_out, cal_command_out}, ((32'hC0 + k) << 4) | k);
      chk(cal_trim_sel_out, k < 12 ? 32'h1 << k : 32'h0);
    end
    // word accesses only on the timer window
    for (k = 0; k < 4; k++) wr(6'h18 + 2 * k, 32'h1000 + k);
    for (k = 0; k < 4; k++) rd(6'h18 + 2 * k, 32'h1000 + k);
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    @(posedge core_clk_in);
    nrst_in <= 1'b1;
    #1;
    chk(digout_bits_out, 32'h0);
    wrap_up;
  end
endmodule
